// [src/mhs_top.sv]
// Modem host interface: SPI register slave, FIFOs, encoder feed, jabber, UART input, IRQ
//
// Behaviour
// R01: Rx FIFO reaching upper-nibble level threshold raises event, IRQ unless mask bit 7.
// R02: Tx data stays queued while demodulator active with carrier present.
// R03: Host sets request-to-send, modem control bit 0, to take the line.
// R04: Modulator active sets clear-to-send status bit 0, IRQ unless mask bit 0.
// R05: Tx FIFO level event from low-nibble threshold, mask bit 4; tx-full flag too.
// R06: Fieldbus rx entries are nine bits; bit 8 marks start, end, slip.
// R07: Transmit and receive FIFOs each hold sixteen entries.
// R08: Encoder sends preamble, start delimiter, data, then stop delimiter when empty.
// R09: Preamble count from modem control 14:12; bit 15 sets Manchester polarity.
// R10: Jabber timeout is setting times 2.048 ms; block 3 s; both flag events.
// R11: UART 8 data odd parity at 1200 in FSK; 8N1 in fieldbus mode.
// R12: Carrier-detect high ignores UART data; in fieldbus transmit it shows jabber.
// R13: Host spaces frames beyond 2442/3000 ns and keeps SCLK at most 12.5 MHz.
// R14: At chip-select rise decode the last 24 bits, or 32 with CRC.
// R15: Only clock modes idle-low second edge and idle-high first edge sampling.
// R16: SDO returns previous frame answer; write echo keeps the received CRC byte.
// R17: Frame bit 23 read flag, bits 22:16 address, bits 15:0 data, CRC appended.
// R18: CRC-8 x^8+x^2+x+1 is checked and bad write frames are dropped.
// R19: Bad CRC read returns fixed word and does not pop the receive FIFO.
// R20: Control bit 2 selects level or edge IRQ, bit 3 the pin polarity.
// R21: Mask bit 0 lets the event drive IRQ, 1 blocks it.
// R22: Level mode latches IRQ until status read; edge mode pulses per new event.
// R23: Carrier detected while receiving sets status bit 1.
`timescale 1ns/1ps
`default_nettype none

module mhs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready,
  output logic [$clog2(DEPTH+1)-1:0] count
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic in_ready_reg;
  wire push = in_valid & in_ready_reg;
  wire pop = out_ready & (count_reg != '0);
  assign count_next = count_reg + CW'(push) - CW'(pop);
  assign in_ready = in_ready_reg;
  assign out_valid = count_reg != '0;
  assign out_data = mem[rd_ptr_reg];
  assign count = count_reg;
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      in_ready_reg <= 1'b1;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + PW'(push);
      rd_ptr_reg <= rd_ptr_reg + PW'(pop);
      count_reg <= count_next;
      in_ready_reg <= count_next != CW'(DEPTH);
    end
  end
endmodule // mhs_fifo

module mhs_top #(
  parameter int JAB_TICK_CYC = mhs_pkg::JAB_TICK_CYC,
  parameter int SILENCE_CYC = mhs_pkg::SILENCE_CYC,
  parameter int UART_FSK_CYC = mhs_pkg::UART_FSK_CYC
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  output logic irq,
  input wire logic uart_rxd,
  input wire logic carrier_in,
  input wire logic rx_valid,
  input wire logic [8:0] rx_data,
  output logic rx_ready,
  output logic enc_valid,
  output logic [7:0] enc_data,
  input wire logic enc_ready,
  output logic manchester_polarity,
  output logic carrier_detect,
  output logic modulator_on
);
  typedef enum logic [1:0] {MHS_IDLE, MHS_PRE, MHS_DATA} mhs_enc_t;

  logic rst_meta_reg, rst_n;
  logic [3:0] pin_meta_reg, pin_sync_reg, pin_prev_reg;
  logic [31:0] shin_reg, resp_reg;
  logic [4:0] sdo_ptr_reg;
  logic sdo_reg, sdo_oe_reg, irq_reg, irq_lat_reg, mod_on_reg, cd_pin_reg;
  logic [15:0] control_reg, mctrl_reg;
  logic [7:0] mask_reg, level_reg, jab_set_reg, status_reg, cond_prev_reg;
  mhs_enc_t enc_state_reg;
  logic [2:0] pre_left_reg;
  logic enc_valid_reg;
  logic [7:0] enc_data_reg;
  logic [16:0] tick_cnt_reg;
  logic [7:0] jab_ticks_reg;
  logic [26:0] silence_cnt_reg;
  logic jab_block_reg, jab_fire_reg, jab_release_reg;
  logic ur_busy_reg, ur_done_reg;
  logic [15:0] ur_cnt_reg;
  logic [3:0] ur_idx_reg;
  logic [9:0] ur_sh_reg;
  logic [4:0] tx_cnt, rx_cnt;
  logic tx_in_ready, tx_out_valid, rx_out_valid;
  logic [7:0] tx_out_data;
  logic [8:0] rx_out_data;

  // Reset release and pin synchronisers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_reg <= mhs_pkg::PIN_RST;
      pin_sync_reg <= mhs_pkg::PIN_RST;
      pin_prev_reg <= mhs_pkg::PIN_RST;
    end else begin
      pin_meta_reg <= {uart_rxd, spi_sdi, spi_cs_n, spi_sclk};
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end
  wire sclk_s = pin_sync_reg[0];
  wire cs_n_s = pin_sync_reg[1];
  wire sdi_s = pin_sync_reg[2];
  wire rxd_s = pin_sync_reg[3];
  wire sclk_fall = pin_prev_reg[0] & ~sclk_s;
  wire sclk_rise = ~pin_prev_reg[0] & sclk_s;
  wire cs_fall = pin_prev_reg[1] & ~cs_n_s;
  wire frame_done = ~pin_prev_reg[1] & cs_n_s;

  function automatic logic [7:0] mhs_crc8(input logic [23:0] d);
    logic [7:0] c;
    c = mhs_pkg::CRC_INIT;
    for (int i = 23; i >= 0; i--) begin
      c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ mhs_pkg::CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction

  // Frame decode; both supported clock modes sample on the falling SCLK edge
  wire crc_en = control_reg[mhs_pkg::CTRL_CRC_EN];
  wire fsk_mode = ~mctrl_reg[mhs_pkg::MC_FIELDBUS];
  wire [23:0] frame = crc_en ? shin_reg[31:8] : shin_reg[23:0]; // R14 R17
  wire crc_ok = ~crc_en | (mhs_crc8(frame) == shin_reg[7:0]); // R18
  wire is_rd = frame[mhs_pkg::FR_RW];
  wire [6:0] addr = frame[22:16];
  wire [15:0] wdat = frame[15:0];
  wire wr_ok = frame_done & ~is_rd & crc_ok; // R18
  wire rd_ok = frame_done & is_rd & crc_ok;
  wire rx_pop = rd_ok & (addr == mhs_pkg::ADDR_RXFIFO); // R19
  wire status_clr = rd_ok & (addr == mhs_pkg::ADDR_STATUS); // R22
  wire [15:0] rx_word = rx_out_valid ? {7'h00, rx_out_data} : 16'h0000; // R06
  wire [15:0] rdata =
    (addr == mhs_pkg::ADDR_CONTROL) ? control_reg :
    (addr == mhs_pkg::ADDR_STATUS) ? {8'h00, status_reg} :
    (addr == mhs_pkg::ADDR_MASK) ? {8'h00, mask_reg} :
    (addr == mhs_pkg::ADDR_MCTRL) ? mctrl_reg :
    (addr == mhs_pkg::ADDR_RXFIFO) ? rx_word :
    (addr == mhs_pkg::ADDR_LEVEL) ? {8'h00, level_reg} :
    (addr == mhs_pkg::ADDR_JABBER) ? {8'h00, jab_set_reg} : 16'h0000;
  wire [23:0] word24 = is_rd ? {frame[23:16], rdata} : frame; // R16
  wire [7:0] resp_crc = is_rd ? mhs_crc8(word24) : shin_reg[7:0]; // R16
  wire [31:0] resp_next = (is_rd & ~crc_ok) ? mhs_pkg::BAD_CRC_WORD : // R19
    {word24, crc_en ? resp_crc : 8'h00};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      shin_reg <= '0;
      resp_reg <= '0;
    end else begin
      if (sclk_fall & ~cs_n_s) begin
        shin_reg <= {shin_reg[30:0], sdi_s}; // R15
      end
      if (frame_done) begin
        resp_reg <= resp_next;
      end
    end
  end
  // SDO launches on CS fall and rising SCLK; idle-high mode shows bit 31 at CS fall
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sdo_reg <= 1'b0;
      sdo_oe_reg <= 1'b0;
      sdo_ptr_reg <= 5'h1f;
    end else begin
      sdo_oe_reg <= ~cs_n_s;
      if (cs_fall) begin
        sdo_reg <= resp_reg[31];
        sdo_ptr_reg <= sclk_s ? 5'h1e : 5'h1f;
      end else if (sclk_rise & ~cs_n_s) begin
        sdo_reg <= resp_reg[sdo_ptr_reg]; // R16
        sdo_ptr_reg <= sdo_ptr_reg - 5'h01;
      end
    end
  end

  // Register writes
  wire wr_control = wr_ok & (addr == mhs_pkg::ADDR_CONTROL);
  wire [15:0] control_next = (control_reg & ~mhs_pkg::CONTROL_WMASK) |
    (wdat & mhs_pkg::CONTROL_WMASK);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      control_reg <= mhs_pkg::CONTROL_RST;
      mask_reg <= mhs_pkg::MASK_RST;
      mctrl_reg <= mhs_pkg::MCTRL_RST;
      level_reg <= mhs_pkg::LEVEL_RST;
      jab_set_reg <= mhs_pkg::JABBER_RST;
    end else begin
      if (wr_control) control_reg <= control_next; // R20
      if (wr_ok & (addr == mhs_pkg::ADDR_MASK)) mask_reg <= wdat[7:0]; // R21
      if (wr_ok & (addr == mhs_pkg::ADDR_MCTRL)) mctrl_reg <= wdat; // R03 R09
      if (wr_ok & (addr == mhs_pkg::ADDR_LEVEL)) level_reg <= wdat[7:0];
      if (wr_ok & (addr == mhs_pkg::ADDR_JABBER)) jab_set_reg <= wdat[7:0]; // R10
    end
  end

  // UART input: feeds the transmit FIFO unless carrier detect is high or an SPI write pushes the FIFO in the same cycle
  wire [15:0] ur_bit = fsk_mode ? 16'(UART_FSK_CYC - 1) : 16'(mhs_pkg::UART_FB_CYC - 1);
  wire [3:0] ur_last = fsk_mode ? 4'ha : 4'h9; // R11
  wire [7:0] ur_byte = fsk_mode ? ur_sh_reg[7:0] : ur_sh_reg[8:1];
  wire ur_good = ur_sh_reg[9] & (~fsk_mode | (^ur_sh_reg[8:0])); // R11
  wire spi_push = wr_ok & (addr == mhs_pkg::ADDR_TXFIFO);
  wire ur_push = ur_done_reg & ur_good & ~cd_pin_reg & ~spi_push; // R12
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ur_busy_reg <= 1'b0;
      ur_done_reg <= 1'b0;
      ur_cnt_reg <= '0;
      ur_idx_reg <= '0;
      ur_sh_reg <= '0;
    end else begin
      ur_done_reg <= 1'b0;
      if (!ur_busy_reg) begin
        if (!rxd_s) begin
          ur_busy_reg <= 1'b1;
          ur_cnt_reg <= {1'b0, ur_bit[15:1]};
          ur_idx_reg <= 4'h0;
        end
      end else if (ur_cnt_reg != 16'h0000) begin
        ur_cnt_reg <= ur_cnt_reg - 16'h0001;
      end else begin
        ur_cnt_reg <= ur_bit;
        if (ur_idx_reg == 4'h0 && rxd_s) begin
          ur_busy_reg <= 1'b0;
        end else begin
          if (ur_idx_reg != 4'h0) ur_sh_reg <= {rxd_s, ur_sh_reg[9:1]};
          ur_idx_reg <= ur_idx_reg + 4'h1;
          if (ur_idx_reg == ur_last) begin
            ur_busy_reg <= 1'b0;
            ur_done_reg <= 1'b1;
          end
        end
      end
    end
  end

  // Encoder feed
  wire enc_slot = ~enc_valid_reg | enc_ready;
  wire tx_active = (enc_state_reg != MHS_IDLE) | enc_valid_reg;
  wire fb_start = ~fsk_mode & tx_out_valid & ~carrier_in & ~jab_block_reg; // R08
  wire fsk_start = fsk_mode & tx_out_valid & mod_on_reg; // R02
  // In FSK mode data only leaves while the modulator holds the line
  wire tx_pop = enc_slot & tx_out_valid & ~jab_block_reg & (~fsk_mode | mod_on_reg) &
    ((enc_state_reg == MHS_DATA) | ((enc_state_reg == MHS_IDLE) & fsk_start)); // R02
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      enc_state_reg <= MHS_IDLE;
      pre_left_reg <= '0;
      enc_valid_reg <= 1'b0;
      enc_data_reg <= '0;
    end else if (enc_slot) begin
      enc_valid_reg <= 1'b0;
      case (enc_state_reg)
        MHS_IDLE: begin
          if (fb_start) begin
            enc_valid_reg <= 1'b1;
            enc_data_reg <= mhs_pkg::PREAMBLE_BYTE;
            pre_left_reg <= mctrl_reg[mhs_pkg::MC_PRE_LSB +: 3]; // R09
            enc_state_reg <= MHS_PRE;
          end else if (fsk_start) begin
            enc_valid_reg <= 1'b1;
            enc_data_reg <= tx_out_data;
            enc_state_reg <= MHS_DATA;
          end
        end
        MHS_PRE: begin
          enc_valid_reg <= 1'b1;
          if (pre_left_reg != 3'h0) begin
            enc_data_reg <= mhs_pkg::PREAMBLE_BYTE;
            pre_left_reg <= pre_left_reg - 3'h1;
          end else begin
            enc_data_reg <= mhs_pkg::START_DELIM; // R08
            enc_state_reg <= MHS_DATA;
          end
        end
        MHS_DATA: begin
          if (tx_pop) begin
            enc_valid_reg <= 1'b1;
            enc_data_reg <= tx_out_data;
          end else begin
            enc_valid_reg <= ~fsk_mode;
            enc_data_reg <= mhs_pkg::STOP_DELIM; // R08
            enc_state_reg <= MHS_IDLE;
          end
        end
        default: enc_state_reg <= MHS_IDLE;
      endcase
    end
  end

  // Jabber inhibitor: counts 2.048 ms ticks of transmission, then 3 s of silence
  wire jab_run = tx_active & (jab_set_reg != 8'h00) & ~jab_block_reg;
  wire tick = tick_cnt_reg == 17'(JAB_TICK_CYC - 1);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_reg <= '0;
      jab_ticks_reg <= '0;
      silence_cnt_reg <= '0;
      jab_block_reg <= 1'b0;
      jab_fire_reg <= 1'b0;
      jab_release_reg <= 1'b0;
    end else begin
      jab_fire_reg <= 1'b0;
      jab_release_reg <= 1'b0;
      if (!jab_run) begin
        tick_cnt_reg <= '0;
        jab_ticks_reg <= '0;
      end else if (tick) begin
        tick_cnt_reg <= '0;
        jab_ticks_reg <= jab_ticks_reg + 8'h01;
        if (jab_ticks_reg + 8'h01 == jab_set_reg) begin
          jab_block_reg <= 1'b1; // R10
          jab_fire_reg <= 1'b1;
          silence_cnt_reg <= '0;
        end
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 17'h00001;
      end
      if (jab_block_reg) begin
        silence_cnt_reg <= silence_cnt_reg + 27'h0000001;
        if (silence_cnt_reg == 27'(SILENCE_CYC - 1)) begin
          jab_block_reg <= 1'b0; // R10
          jab_release_reg <= 1'b1;
        end
      end
    end
  end

  // Status events, masking and the interrupt pin
  wire [7:0] level_thr_rx = {4'h0, level_reg[7:4]};
  wire [7:0] level_thr_tx = {4'h0, level_reg[3:0]};
  wire [7:0] cond;
  assign cond[mhs_pkg::ST_CTS] = mod_on_reg; // R04
  assign cond[mhs_pkg::ST_CD] = carrier_in & rx_valid; // R23
  assign cond[mhs_pkg::ST_RX_FULL] = rx_cnt == 5'(mhs_pkg::FIFO_DEPTH);
  assign cond[mhs_pkg::ST_TX_FULL] = tx_cnt == 5'(mhs_pkg::FIFO_DEPTH); // R05
  assign cond[mhs_pkg::ST_TX_LEVEL] = (level_thr_tx != 8'h00) & ({3'h0, tx_cnt} >= level_thr_tx);
  assign cond[mhs_pkg::ST_JABBER_FIRED_FLAG] = jab_fire_reg; // R10
  assign cond[mhs_pkg::ST_JABBER_RELEASED_FLAG] = jab_release_reg; // R10
  assign cond[mhs_pkg::ST_RX_LEVEL] = (level_thr_rx != 8'h00) & ({3'h0, rx_cnt} >= level_thr_rx);
  wire [7:0] ev = cond & ~cond_prev_reg;
  wire [7:0] status_next = (status_clr ? 8'h00 : status_reg) | ev;
  wire irq_new = |(ev & ~mask_reg); // R01 R04 R05 R21
  wire irq_lat_next = (~status_clr & irq_lat_reg) | irq_new; // R22
  wire irq_active = control_reg[mhs_pkg::CTRL_IRQ_LEVEL] ? irq_lat_next : irq_new; // R20 R22
  wire fsk_mod = fsk_mode & mctrl_reg[mhs_pkg::MC_RTS] & ~carrier_in; // R02 R04
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cond_prev_reg <= '0;
      status_reg <= '0;
      irq_lat_reg <= 1'b0;
      irq_reg <= 1'b1;
      mod_on_reg <= 1'b0;
      cd_pin_reg <= 1'b0;
    end else begin
      cond_prev_reg <= cond;
      status_reg <= status_next;
      irq_lat_reg <= irq_lat_next;
      irq_reg <= irq_active ~^ control_reg[mhs_pkg::CTRL_IRQ_POL]; // R20
      mod_on_reg <= fsk_mode ? fsk_mod : tx_active;
      cd_pin_reg <= fsk_mode ? carrier_in : (tx_active ? jab_block_reg : carrier_in); // R12
    end
  end

  mhs_fifo #(.WIDTH(8), .DEPTH(mhs_pkg::FIFO_DEPTH)) u_tx_fifo ( // R07
    .clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(spi_push | ur_push),
    .in_data(spi_push ? wdat[7:0] : ur_byte),
    .in_ready(tx_in_ready),
    .out_valid(tx_out_valid),
    .out_data(tx_out_data),
    .out_ready(tx_pop),
    .count(tx_cnt)
  );
  mhs_fifo #(.WIDTH(9), .DEPTH(mhs_pkg::FIFO_DEPTH)) u_rx_fifo ( // R06 R07
    .clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(rx_valid),
    .in_data(rx_data),
    .in_ready(rx_ready),
    .out_valid(rx_out_valid),
    .out_data(rx_out_data),
    .out_ready(rx_pop),
    .count(rx_cnt)
  );

  assign spi_sdo = sdo_reg;
  assign spi_sdo_oe = sdo_oe_reg;
  assign irq = irq_reg;
  assign enc_valid = enc_valid_reg;
  assign enc_data = enc_data_reg;
  assign manchester_polarity = mctrl_reg[mhs_pkg::MC_POLARITY]; // R09
  assign carrier_detect = cd_pin_reg;
  assign modulator_on = mod_on_reg;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_rx_level_ev: assert property (ev[mhs_pkg::ST_RX_LEVEL] |=> status_reg[7]) // R01
    else $error("rx level event not recorded");
  a_hold_carrier: assert property (fsk_mode & tx_pop |-> !$past(carrier_in)) // R02
    else $error("tx data left fifo while carrier present");
  a_cts_status: assert property ($rose(mod_on_reg) |=> status_reg[0]) // R04
    else $error("cts status not set");
  a_tx_full_flag: assert property (ev[mhs_pkg::ST_TX_FULL] |=> status_reg[3]) // R05
    else $error("tx full not flagged");
  a_start_delim: assert property (enc_slot & enc_state_reg == MHS_PRE & pre_left_reg == 3'h0
    |=> enc_valid_reg & enc_data_reg == 8'h4d) // R08
    else $error("start delimiter missing");
  a_stop_empty: assert property (enc_slot & ~fsk_mode & enc_state_reg == MHS_DATA & ~tx_pop
    |=> enc_valid_reg & enc_data_reg == 8'h26 & enc_state_reg == MHS_IDLE) // R08
    else $error("stop delimiter missing");
  a_jab_block: assert property (jab_fire_reg |-> jab_block_reg [*8]) // R10
    else $error("jabber did not block");
  a_crc_drop: assert property (frame_done & ~is_rd & ~crc_ok |=> $stable(mask_reg)
    & $stable(mctrl_reg) & $stable(jab_set_reg)) // R18
    else $error("bad crc write took effect");
  a_bad_read: assert property (frame_done & is_rd & ~crc_ok |=> resp_reg == 32'h08000000
    & (rx_cnt >= $past(rx_cnt))) // R19
    else $error("bad crc read mishandled");
  a_masked_idle: assert property (~control_reg[2] & ~irq_new |=> irq == ~$past(control_reg[3])) // R21
    else $error("irq active without unmasked event");
  a_level_latch: assert property (control_reg[2] & irq_lat_reg & ~status_clr
    |=> irq == control_reg[3] & irq_lat_reg) // R22
    else $error("level irq dropped before status read");
  a_cd_status: assert property (ev[mhs_pkg::ST_CD] |=> status_reg[1]) // R23
    else $error("carrier status not set");
  c_fb_packet: cover property (enc_state_reg == MHS_PRE ##[1:40] enc_state_reg == MHS_IDLE);
  c_good_write: cover property (wr_ok & crc_en);
  c_rx_pop: cover property (rx_pop & rx_out_valid);
  c_uart_push: cover property (ur_push);
endmodule // mhs_top

`default_nettype wire

// [src/mhs_pkg.sv]
// Constants shared by the modem host interface: register map, fields, codes and timing
package mhs_pkg;
  // Register offsets (7-bit frame address)
  localparam logic [6:0] ADDR_CONTROL = 7'h02;
  localparam logic [6:0] ADDR_STATUS = 7'h20;
  localparam logic [6:0] ADDR_MASK = 7'h21;
  localparam logic [6:0] ADDR_MCTRL = 7'h22;
  localparam logic [6:0] ADDR_TXFIFO = 7'h23;
  localparam logic [6:0] ADDR_RXFIFO = 7'h24;
  localparam logic [6:0] ADDR_LEVEL = 7'h25;
  localparam logic [6:0] ADDR_JABBER = 7'h27;
  // Control register
  localparam logic [15:0] CONTROL_RST = 16'h8042;
  localparam logic [15:0] CONTROL_WMASK = 16'hf05f;
  localparam int CTRL_IRQ_LEVEL = 2;
  localparam int CTRL_IRQ_POL = 3;
  localparam int CTRL_CRC_EN = 4;
  // Status and mask bit positions
  localparam int ST_CTS = 0;
  localparam int ST_CD = 1;
  localparam int ST_RX_FULL = 2;
  localparam int ST_TX_FULL = 3;
  localparam int ST_TX_LEVEL = 4;
  localparam int ST_JABBER_FIRED_FLAG = 5;
  localparam int ST_JABBER_RELEASED_FLAG = 6;
  localparam int ST_RX_LEVEL = 7;
  localparam logic [7:0] MASK_RST = 8'hff;
  // Modem control register
  localparam logic [15:0] MCTRL_RST = 16'h0000;
  localparam int MC_RTS = 0;
  localparam int MC_FIELDBUS = 8;
  localparam int MC_PRE_LSB = 12;
  localparam int MC_POLARITY = 15;
  localparam logic [7:0] LEVEL_RST = 8'h00;
  localparam logic [7:0] JABBER_RST = 8'h00;
  // Frame layout and CRC
  localparam int FR_RW = 23;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [31:0] BAD_CRC_WORD = 32'h08000000;
  // Receive markers and encoder symbols
  localparam logic [8:0] RX_SOP = 9'h14d;
  localparam logic [8:0] RX_EOP = 9'h126;
  localparam logic [8:0] RX_SLIP = 9'h100;
  localparam logic [7:0] PREAMBLE_BYTE = 8'h55;
  localparam logic [7:0] START_DELIM = RX_SOP[7:0];
  localparam logic [7:0] STOP_DELIM = RX_EOP[7:0];
  // FIFOs
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_CW = 5;
  // Pin synchroniser reset image {uart_rxd, spi_sdi, spi_cs_n, spi_sclk}
  localparam logic [3:0] PIN_RST = 4'ha;
  // Timing
  localparam int CLK_MHZ = 40;
  localparam int JAB_TICK_NS = 2048000;
  localparam int JAB_TICK_CYC = JAB_TICK_NS * CLK_MHZ / 1000;
  localparam int SILENCE_MS = 3000;
  localparam int SILENCE_CYC = SILENCE_MS * CLK_MHZ * 1000;
  localparam int UART_FSK_HZ = 1200;
  localparam int UART_FB_HZ = 57600;
  localparam int UART_FSK_CYC = CLK_MHZ * 1000000 / UART_FSK_HZ;
  localparam int UART_FB_CYC = CLK_MHZ * 1000000 / UART_FB_HZ;
endpackage

// [test/mhs_host_model.sv]
// Host model: SPI master, idle-low clock, data sampled on the second edge
`timescale 1ns/1ps
`default_nettype none
module mhs_host_model (
  input wire logic clk,
  input wire logic sdo,
  output var logic sclk,
  output var logic cs_n,
  output var logic sdi
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end
  task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
    @(negedge clk);
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      repeat (4) @(negedge clk);
      sclk = 1'b1;
      sdi = tx[i];
      repeat (4) @(negedge clk);
      rx = {rx[30:0], sdo};
      sclk = 1'b0;
    end
    repeat (4) @(negedge clk);
    cs_n = 1'b1;
    sdi = ~sdi;
    repeat (130) @(negedge clk);
  endtask
endmodule // mhs_host_model
`default_nettype wire

// [test/tb_top.sv]
// Testbench: register, FIFO, encoder and interrupt checks over SPI
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic sclk, cs_n, sdi, sdo, irq, rx_valid, rx_ready, enc_valid, enc_ready, pol;
  logic [8:0] rx_data;
  logic [7:0] enc_data;
  logic [7:0] got[$];
  logic [23:0] r;
  logic [31:0] r32;
  logic sdo_oe, rxd, carrier, cd_pin, mod_on;
  int errors = 0;
  int samples_checked = 0;
  always #12.5 sys_clk = ~sys_clk;
  // A released SDO shows the inverse so a late enable is caught
  mhs_host_model host (.clk(sys_clk), .sdo(sdo_oe ? sdo : ~sdo), .sclk(sclk), .cs_n(cs_n),
    .sdi(sdi));
  mhs_top #(.JAB_TICK_CYC(20), .SILENCE_CYC(50), .UART_FSK_CYC(40)) dut (
    .sys_clk(sys_clk), .rstn(rstn), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_sdi(sdi),
    .spi_sdo(sdo), .spi_sdo_oe(sdo_oe), .irq(irq), .uart_rxd(rxd), .carrier_in(carrier),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready), .enc_valid(enc_valid),
    .enc_data(enc_data), .enc_ready(enc_ready), .manchester_polarity(pol),
    .carrier_detect(cd_pin), .modulator_on(mod_on));
  always @(negedge sys_clk) begin
    if (enc_valid === 1'b1 && enc_ready) begin
      got.push_back(enc_data);
    end
  end
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  function automatic logic [7:0] crc8(input logic [23:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction
  task automatic rd(input logic [6:0] a);
    host.xfer({8'h00, 1'b1, a, 16'h0000}, 24, r32);
    r = r32[23:0];
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    host.xfer({8'h00, 1'b0, a, d}, 24, r32);
    r = r32[23:0];
  endtask
  // CRC frame; bad flips CRC bits to corrupt it
  task automatic xc(input logic [23:0] f, input logic [7:0] bad);
    host.xfer({f, crc8(f) ^ bad}, 32, r32);
    r = r32[31:8];
  endtask
  // FSK character: start, 8 data LSB first, odd parity, stop; 40 clocks a bit
  task automatic uart_send(input logic [7:0] b);
    logic [10:0] f;
    f = {1'b1, ~^b, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd = f[i];
      repeat (40) @(negedge sys_clk);
    end
  endtask
  task automatic test_done();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(negedge sys_clk);
    errors++;
    test_done();
  end
  initial begin
    rx_valid = 1'b0;
    rx_data = 9'h000;
    enc_ready = 1'b1;
    rxd = 1'b1;
    carrier = 1'b0;
    repeat (4) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (8) @(negedge sys_clk);
    wr(mhs_pkg::ADDR_JABBER, 16'h00a5);
    rd(mhs_pkg::ADDR_CONTROL);
    chk(r, {1'b0, mhs_pkg::ADDR_JABBER, 16'h00a5});
    rd(mhs_pkg::ADDR_MASK);
    chk(r, {1'b1, mhs_pkg::ADDR_CONTROL, 16'h8042});
    rd(mhs_pkg::ADDR_JABBER);
    chk(r, {1'b1, mhs_pkg::ADDR_MASK, 16'h00ff});
    rd(7'h7f);
    chk(r, {1'b1, mhs_pkg::ADDR_JABBER, 16'h00a5});
    wr(mhs_pkg::ADDR_MCTRL, 16'h9100);
    chk(r, {1'b1, 7'h7f, 16'h0000});
    wr(mhs_pkg::ADDR_TXFIFO, 16'h003c);
    chk({23'h0, pol}, 24'h000001);
    foreach (got[i]) begin
      chk({16'h0, got[i]}, {16'h0, i < 2 ? 8'h55 : i == 2 ? 8'h4d : i == 3 ? 8'h3c : 8'h26});
    end
    chk(24'(got.size()), 24'd5);
    wr(mhs_pkg::ADDR_LEVEL, 16'h0010);
    wr(mhs_pkg::ADDR_MASK, 16'h007f);
    wr(mhs_pkg::ADDR_CONTROL, 16'h8046);
    rx_valid = 1'b1;
    rx_data = mhs_pkg::RX_SOP;
    @(negedge sys_clk);
    rx_valid = 1'b0;
    repeat (8) @(negedge sys_clk);
    chk({23'h0, irq}, 24'h0);
    rd(mhs_pkg::ADDR_STATUS);
    chk({23'h0, irq}, 24'h1);
    rd(mhs_pkg::ADDR_RXFIFO);
    chk(r, {1'b1, mhs_pkg::ADDR_STATUS, 16'h0081});
    rd(mhs_pkg::ADDR_RXFIFO);
    chk(r, {1'b1, mhs_pkg::ADDR_RXFIFO, 7'h00, mhs_pkg::RX_SOP});
    rd(7'h7f);
    chk(r, {1'b1, mhs_pkg::ADDR_RXFIFO, 16'h0000});
    carrier = 1'b1;
    rx_valid = 1'b1;
    rx_data = mhs_pkg::RX_EOP;
    @(negedge sys_clk);
    rx_valid = 1'b0;
    wr(mhs_pkg::ADDR_MCTRL, 16'h0001);
    uart_send(8'ha6);
    wr(mhs_pkg::ADDR_TXFIFO, 16'h0033);
    chk({23'h0, cd_pin}, 24'h1);
    chk({23'h0, mod_on}, 24'h0);
    chk(24'(got.size()), 24'd5);
    carrier = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk({23'h0, mod_on}, 24'h1);
    uart_send(8'h3a);
    chk(24'(got.size()), 24'd7);
    chk({16'h0, got[5]}, 24'h000033);
    chk({16'h0, got[6]}, 24'h00003a);
    rd(mhs_pkg::ADDR_STATUS);
    rd(7'h7f);
    chk(r, {1'b1, mhs_pkg::ADDR_STATUS, 16'h0083});
    wr(mhs_pkg::ADDR_CONTROL, 16'h8056);
    xc({1'b0, mhs_pkg::ADDR_MASK, 16'h007e}, 8'h01);
    chk(r, {1'b0, mhs_pkg::ADDR_CONTROL, 16'h8056});
    xc({1'b0, mhs_pkg::ADDR_LEVEL, 16'h0010}, 8'h00);
    xc({1'b1, mhs_pkg::ADDR_MASK, 16'h0000}, 8'h00);
    chk(r, {1'b0, mhs_pkg::ADDR_LEVEL, 16'h0010});
    chk({16'h0, r32[7:0]}, {16'h0, crc8({1'b0, mhs_pkg::ADDR_LEVEL, 16'h0010})});
    xc({1'b1, mhs_pkg::ADDR_RXFIFO, 16'h0000}, 8'h01);
    chk(r, {1'b1, mhs_pkg::ADDR_MASK, 16'h007f});
    xc({1'b1, mhs_pkg::ADDR_RXFIFO, 16'h0000}, 8'h00);
    chk(r, mhs_pkg::BAD_CRC_WORD[31:8]);
    xc({1'b1, 7'h7f, 16'h0000}, 8'h00);
    chk(r, {1'b1, mhs_pkg::ADDR_RXFIFO, 7'h00, mhs_pkg::RX_EOP});
    test_done();
  end
endmodule // tb_top
`default_nettype wire
